//--- cfso_pkg.sv
package cfso_pkg;
    localparam int unsigned cfso_enable_bit_pos = 0;
    localparam logic [3:0] cfso_ctrl_reset = 4'h0;
    localparam logic [3:0] cfso_nibble_zero = 4'h0;
    localparam logic [1:0] cfso_imm_cycles = 2'h2;
    localparam logic [1:0] cfso_one_cycle = 2'h1;

    typedef enum logic [3:0] {
        cfso_op_none = 4'h1,
        cfso_op_acc_eq_imm = 4'h2,
        cfso_op_acc_eq_mem = 4'h4,
        cfso_op_ext0_flag = 4'h8
    } cfso_op_t;

    typedef struct packed {
        logic valid;
        cfso_op_t op;
        logic [3:0] imm;
        logic two_word;
    } cfso_instr_t;

    typedef struct packed {
        logic [3:0] acc;
        logic [3:0] mem_nibble;
        logic [3:0] int_control_reg;
        logic ext0_request_flag;
    } cfso_state_t;
endpackage

//--- cfso_skip_ops.sv
module cfso_skip_ops
    import cfso_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire cfso_instr_t instr,
    input wire cfso_state_t core,
    output logic instr_busy,
    output logic suppress,
    output logic skip_pending,
    output logic ext0_flag_clear
);
    typedef enum logic [2:0] {
        cfso_st_idle = 3'b001,
        cfso_st_imm2 = 3'b010,
        cfso_st_skip = 3'b100
    } cfso_st_t;

    cfso_st_t state;
    logic [3:0] imm_hold;
    logic [1:0] skip_count;
    logic ext0_enable;
    logic take_new;
    logic next_skip;
    logic [1:0] next_skip_cycles;

    assign ext0_enable = core.int_control_reg[cfso_enable_bit_pos];
    assign take_new = instr.valid && (state == cfso_st_idle);
    assign instr_busy = (state == cfso_st_imm2);
    assign suppress = instr.valid && (state == cfso_st_skip);

    always_comb begin
        next_skip = 1'b0;
        next_skip_cycles = cfso_one_cycle;
        if (state == cfso_st_imm2) begin
            next_skip = (core.acc == imm_hold);
        end else if (take_new) begin
            unique case (instr.op)
                cfso_op_acc_eq_mem: next_skip = (core.acc == core.mem_nibble);
                cfso_op_ext0_flag: next_skip = !ext0_enable && core.ext0_request_flag;
                cfso_op_acc_eq_imm: next_skip = 1'b0;
                cfso_op_none: next_skip = 1'b0;
                default: next_skip = 1'b0;
            endcase
        end
        if (instr.two_word) begin
            next_skip_cycles = cfso_imm_cycles;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ext0_flag_clear <= 1'b0;
        end else begin
            ext0_flag_clear <= take_new && (instr.op == cfso_op_ext0_flag) && !ext0_enable;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            imm_hold <= cfso_nibble_zero;
        end else if (take_new && instr.op == cfso_op_acc_eq_imm) begin
            imm_hold <= instr.imm;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= cfso_st_idle;
            skip_count <= 2'h0;
            skip_pending <= 1'b0;
        end else begin
            unique case (state)
                cfso_st_idle: begin
                    if (take_new && instr.op == cfso_op_acc_eq_imm) begin
                        state <= cfso_st_imm2;
                    end else if (next_skip) begin
                        state <= cfso_st_skip;
                        skip_pending <= 1'b1;
                    end
                end
                cfso_st_imm2: begin
                    if (next_skip) begin
                        state <= cfso_st_skip;
                        skip_pending <= 1'b1;
                    end else begin
                        state <= cfso_st_idle;
                    end
                end
                cfso_st_skip: begin
                    if (instr.valid) begin
                        if (skip_count == 2'h0 && next_skip_cycles == cfso_imm_cycles) begin
                            skip_count <= 2'h1;
                        end else begin
                            skip_count <= 2'h0;
                            state <= cfso_st_idle;
                            skip_pending <= 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    property imm_skip_p;
        @(posedge clk_sys) disable iff (rst)
        (state == cfso_st_imm2 && core.acc == imm_hold) |=> state == cfso_st_skip;
    endproperty
    imm_eq_skip_a: assert property (imm_skip_p) else $error("Equal immediate did not skip.");

    imm_ne_run_a: assert property (@(posedge clk_sys) disable iff (rst)
        (state == cfso_st_imm2 && core.acc != imm_hold) |=> state == cfso_st_idle)
        else $error("Unequal immediate skipped.");

    // Checks on the two-cycle immediate compare and the one-cycle memory compare.
    sequence imm_take_s;
        take_new && instr.op == cfso_op_acc_eq_imm;
    endsequence

    sequence busy_once_s;
        instr_busy ##1 !instr_busy;
    endsequence

    property imm_two_cycle_p;
        @(posedge clk_sys) disable iff (rst)
        imm_take_s |=> busy_once_s;
    endproperty
    imm_two_cycle_a: assert property (imm_two_cycle_p) else $error("Immediate compare not two cycles.");

    property imm_capture_p;
        @(posedge clk_sys) disable iff (rst)
        imm_take_s |=> imm_hold == $past(instr.imm);
    endproperty
    imm_capture_a: assert property (imm_capture_p) else $error("Immediate value not captured.");

    property busy_no_decode_p;
        @(posedge clk_sys) disable iff (rst)
        instr_busy |=> !ext0_flag_clear && !instr_busy;
    endproperty
    busy_no_decode_a: assert property (busy_no_decode_p) else $error("Busy cycle decoded a word.");

    property busy_keep_imm_p;
        @(posedge clk_sys) disable iff (rst)
        instr_busy |=> imm_hold == $past(imm_hold);
    endproperty
    busy_keep_imm_a: assert property (busy_keep_imm_p) else $error("Busy cycle changed the immediate.");

    sequence mem_op_s;
        take_new && instr.op == cfso_op_acc_eq_mem;
    endsequence
    mem_eq_skip_a: assert property (@(posedge clk_sys) disable iff (rst)
        mem_op_s ##0 (core.acc == core.mem_nibble) |=> skip_pending)
        else $error("Equal memory did not skip.");

    mem_ne_run_a: assert property (@(posedge clk_sys) disable iff (rst)
        mem_op_s ##0 (core.acc != core.mem_nibble) |=> !skip_pending)
        else $error("Unequal memory skipped.");

    property mem_one_cycle_p;
        @(posedge clk_sys) disable iff (rst)
        mem_op_s |=> !instr_busy;
    endproperty
    mem_one_cycle_a: assert property (mem_one_cycle_p) else $error("Memory compare took a busy cycle.");

    property skip_source_p;
        @(posedge clk_sys) disable iff (rst)
        (state == cfso_st_idle && !(take_new && (instr.op == cfso_op_acc_eq_mem || instr.op == cfso_op_ext0_flag)))
            |=> !skip_pending;
    endproperty
    skip_source_a: assert property (skip_source_p) else $error("Skip raised without a compare.");

    // Checks on the flag test and its clear pulse.
    sequence flag_op_s;
        take_new && instr.op == cfso_op_ext0_flag;
    endsequence
    flag_skip_a: assert property (@(posedge clk_sys) disable iff (rst)
        flag_op_s ##0 (!ext0_enable && core.ext0_request_flag) |=> skip_pending)
        else $error("Set flag did not skip.");

    flag_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
        flag_op_s ##0 !core.int_control_reg[cfso_enable_bit_pos] |=> ext0_flag_clear)
        else $error("Flag test did not clear.");

    flag_nop_a: assert property (@(posedge clk_sys) disable iff (rst)
        flag_op_s ##0 ext0_enable |=> !ext0_flag_clear && !skip_pending)
        else $error("Enabled flag test acted.");

    property flag_zero_p;
        @(posedge clk_sys) disable iff (rst)
        flag_op_s ##0 (!ext0_enable && !core.ext0_request_flag) |=> ext0_flag_clear && !skip_pending;
    endproperty
    flag_zero_a: assert property (flag_zero_p) else $error("Clear flag test misbehaved.");

    property clear_source_p;
        @(posedge clk_sys) disable iff (rst)
        !(take_new && instr.op == cfso_op_ext0_flag) |=> !ext0_flag_clear;
    endproperty
    clear_source_a: assert property (clear_source_p) else $error("Clear pulse without a flag test.");

    // Checks on the skip window and the suppressed instruction.
    skip_suppress_a: assert property (@(posedge clk_sys) disable iff (rst)
        (skip_pending && instr.valid && !instr.two_word) |-> suppress ##1 !skip_pending)
        else $error("Skipped instruction not suppressed.");

    sequence two_word_skip_s;
        skip_pending && instr.valid && instr.two_word && skip_count == 2'h0;
    endsequence

    property two_word_first_p;
        @(posedge clk_sys) disable iff (rst)
        two_word_skip_s |-> suppress ##1 skip_pending;
    endproperty
    two_word_first_a: assert property (two_word_first_p) else $error("First skipped word mishandled.");

    property two_word_last_p;
        @(posedge clk_sys) disable iff (rst)
        (skip_pending && instr.valid && skip_count == 2'h1) |-> suppress ##1 !skip_pending;
    endproperty
    two_word_last_a: assert property (two_word_last_p) else $error("Second skipped word mishandled.");

    property pend_hold_p;
        @(posedge clk_sys) disable iff (rst)
        (skip_pending && !instr.valid) |=> skip_pending;
    endproperty
    pend_hold_a: assert property (pend_hold_p) else $error("Skip dropped without an instruction.");

    property no_clear_skip_p;
        @(posedge clk_sys) disable iff (rst)
        (skip_pending && instr.valid) |=> !ext0_flag_clear;
    endproperty
    no_clear_skip_a: assert property (no_clear_skip_p) else $error("Suppressed word cleared flag.");
endmodule // cfso_skip_ops

//--- compare_and_flag_skip_ops_tb.sv
module compare_and_flag_skip_ops_tb
    import cfso_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys;
    logic rst;
    cfso_instr_t instr;
    cfso_state_t core;
    logic instr_busy;
    logic suppress;
    logic skip_pending;
    logic ext0_flag_clear;
    int n_fail = 0;
    int n_compared = 0;
    logic [3:0] q[$];
    logic [3:0] got;
    cfso_op_t ops[3] = '{cfso_op_acc_eq_imm, cfso_op_acc_eq_mem, cfso_op_ext0_flag};

    cfso_skip_ops dut (.clk_sys(clk_sys), .rst(rst), .instr(instr), .core(core), .instr_busy(instr_busy),
        .suppress(suppress), .skip_pending(skip_pending), .ext0_flag_clear(ext0_flag_clear));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic finish_test();
        $display("Compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One cycle of stimulus; e holds the expected busy, suppress, pending and clear outputs.
    task automatic step(input logic v, input cfso_op_t op, input logic tw, input logic [3:0] e);
        @(posedge clk_sys);
        #1;
        instr.valid = v;
        instr.op = op;
        instr.two_word = tw;
        q.push_back(e);
    endtask

    task automatic run(input cfso_op_t op);
        logic sk;
        logic cl;
        logic tw;
        logic gap;
        tw = 1'($urandom);
        gap = 1'($urandom);
        cl = (op == cfso_op_ext0_flag) && !core.int_control_reg[cfso_enable_bit_pos];
        sk = (op == cfso_op_acc_eq_imm) ? core.acc == instr.imm :
             (op == cfso_op_acc_eq_mem) ? core.acc == core.mem_nibble : cl && core.ext0_request_flag;
        step(1'b1, op, 1'b0, 4'h0);
        if (op == cfso_op_acc_eq_imm) begin
            step(1'b0, cfso_op_none, 1'b0, 4'h8);
        end
        if (gap) begin
            step(1'b0, cfso_op_none, 1'b0, {2'b00, sk, cl});
            cl = 1'b0;
        end
        step(1'b1, cfso_op_none, tw, {1'b0, sk, sk, cl});
        if (sk && tw) begin
            step(1'b1, cfso_op_none, 1'b0, 4'h6);
        end
        step(1'b0, cfso_op_none, 1'b0, 4'h0);
    endtask

    always @(negedge clk_sys) begin
        if (q.size() > 0) begin
            got = {instr_busy, suppress, skip_pending, ext0_flag_clear};
            n_compared++;
            if (got !== q[0]) begin
                n_fail++;
                $display("Error at %0t: expected %h, got %h", $time, q[0], got);
            end
            void'(q.pop_front());
        end
    end

    initial begin
        rst = 1'b1;
        instr = {1'b0, cfso_op_none, 4'h0, 1'b0};
        core = '0;
        void'($urandom(11838));
        repeat (8) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        step(1'b0, cfso_op_none, 1'b0, 4'h0);
        $display("Reset test done");
        for (int i = 0; i < 120; i++) begin
            core = cfso_state_t'(13'($urandom));
            instr.imm = i[2] ? core.acc : 4'($urandom);
            if (i[3]) begin
                core.mem_nibble = core.acc;
            end
            run(ops[i % 3]);
        end
        repeat (2) @(posedge clk_sys);
        $display("Skip test done");
        finish_test();
    end

    initial begin
        #20000;
        n_fail++;
        finish_test();
    end
endmodule // compare_and_flag_skip_ops_tb
